// ### verilog/tmf_top.v
// Timer mode selection, match-A flags, channel 2 phase counting and AXI4-Lite registers
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`include "tmf_defs.vh"

// Operation
// - Mode register resets to 98h on reset and on standby entry.
// - Mode bits 7, 4, 3 ignore writes and read as one.
// - Mode bit 6 selects channel 2 phase counting; zero after reset.
// - Phase counting counts both edges of both count pins up or down.
// - Phase counting overrides channel 2 edge and clock source selection.
// - Clearing, compare, capture and interrupts stay active in phase counting.
// - Mode bit 5: zero flags overflow or underflow, one flags overflow only.
// - Mode bits 2..0 select PWM for channels 2..0; cleared at reset.
// - PWM pin goes high on A match, low on B match.
// - Match-A status register resets to 88h on reset and standby entry.
// - Status bits 7 and 3 ignore writes and read as one.
// - Channel A interrupt requested only when its flag and enable are set.
// - Flag sets when channel counter equals its A register in compare use.
// - Flag sets when capture loads counter value into A register.
// - Software writes only zero to flags to clear; one leaves them.
// - Clear needs a prior read of the flag at one, then zero write.
// - DMA activation by channel A interrupt clears that flag.
// - Overflow is FFFF to 0000, underflow 0000 to FFFF, channel 2 only.
module tmf_top (
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_reset_n,
	input  wire        i_standby,
	// AXI4-Lite write address and data
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	output reg  [1:0]  s_axi_bresp,
	// AXI4-Lite read
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	input  wire [7:0]  s_axi_araddr,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	// Per-channel match events from the counter datapath, and DMA acknowledges
	input  wire [2:0]  i_compare_a_hit,
	input  wire [2:0]  i_compare_b_hit,
	input  wire [2:0]  i_capture_a,
	input  wire [2:0]  i_dma_ack_a,
	// Channel 2 normal clock and its counter
	input  wire        i_ch2_normal_tick,
	input  wire [15:0] i_ch2_count,
	// Quadrature pins
	input  wire        i_quad_input_first,
	input  wire        i_quad_input_second,
	// Mode and pin outputs
	output reg  [2:0]  o_pwm_select,
	output reg  [2:0]  o_capcomp_pin_a,
	output reg         o_phase_count_select,
	output reg         o_ch2_count_up,
	output reg         o_ch2_count_down,
	output reg         o_overflow_flag_set,
	output reg  [2:0]  o_match_a_irq,
	output reg         o_irq
);
	// Channel 2 counter overflow or underflow test on a step
	function wrap_step;
		input [15:0] cnt;
		input [15:0] edge_val;
		input        step;
		begin
			wrap_step = step & (cnt == edge_val);
		end
	endfunction

	reg  [7:0]  mode_q;
	reg  [2:0]  en_q;
	reg  [2:0]  flag_q;
	reg  [2:0]  seen_q;
	reg  [5:0]  ist_q;
	reg  [5:0]  imask_q;
	reg         standby_q;
	reg         pin_first_q;
	reg         pin_second_q;
	reg         aw_have_q;
	reg         w_have_q;
	reg  [7:0]  aw_addr_q;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;
	wire        pin_first;
	wire        pin_second;
	wire        q_up;
	wire        q_down;
	wire        do_write;
	wire        do_read;
	wire        standby_entry;
	wire        phase_mode;
	wire        step_up;
	wire        step_down;
	wire        ovf_ev;
	wire        unf_ev;
	wire        quad_err;
	wire [2:0]  set_ev;
	wire [2:0]  sw_clear;
	wire [7:0]  mode_rd;
	wire [7:0]  stat_rd;
	reg  [31:0] rd_word;
	reg         rd_ok;
	integer     i;

	// Pin synchronisers and quadrature decode
	tmf_sync3 u_sync_first (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_pin     (i_quad_input_first),
		.o_level   (pin_first)
	);
	tmf_sync3 u_sync_second (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_pin     (i_quad_input_second),
		.o_level   (pin_second)
	);
	tmf_quad u_quad (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_first   (pin_first),
		.i_second  (pin_second),
		.o_up      (q_up),
		.o_down    (q_down)
	);

	// Bus handshakes: address and data taken in either order
	assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
	assign do_read  = s_axi_arvalid & s_axi_arready;
	assign standby_entry = i_standby & ~standby_q;
	assign phase_mode = mode_q[`TMF_BIT_PHASE];

	// Phase mode replaces the selected clock entirely
	assign step_up   = phase_mode ? q_up : i_ch2_normal_tick;
	assign step_down = phase_mode & q_down;
	assign ovf_ev = wrap_step(i_ch2_count, `TMF_CNT_MAX, step_up);
	assign unf_ev = wrap_step(i_ch2_count, `TMF_CNT_MIN, step_down);
	// Both clean pin levels moving in one cycle; the decoder drops such a step silently
	assign quad_err = phase_mode & (pin_first ^ pin_first_q) & (pin_second ^ pin_second_q);

	// Compare and capture set flags in every mode
	assign set_ev = i_compare_a_hit | i_capture_a;

	// Zero write clears only a flag read while set
	assign sw_clear = (do_write && aw_addr_q == `TMF_OFS_STAT_A && w_strb_q[0]) ?
		(~w_data_q[2:0] & seen_q) : 3'h0;

	// Reserved bits forced to one on readback
	assign mode_rd = mode_q | `TMF_MODE_RSVD;
	assign stat_rd = {1'b1, en_q, 1'b1, flag_q};

	// Readback mux; unmapped address answers SLVERR
	always @* begin
		rd_word = 32'h0000_0000;
		rd_ok   = 1'b1;
		case (s_axi_araddr)
			`TMF_OFS_MODE:     rd_word = {24'h000000, mode_rd};
			`TMF_OFS_STAT_A:   rd_word = {24'h000000, stat_rd};
			`TMF_OFS_IRQ_STAT: rd_word = {26'h0000000, ist_q};
			`TMF_OFS_IRQ_MASK: rd_word = {26'h0000000, imask_q};
			default:           rd_ok   = 1'b0;
		endcase
	end

	// AXI4-Lite channel state
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_arready <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `TMF_RESP_OKAY;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `TMF_RESP_OKAY;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_have_q     <= 1'b1;
				aw_addr_q     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_have_q     <= 1'b1;
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr_q > `TMF_OFS_IRQ_MASK || aw_addr_q[1:0] != 2'h0) ?
					`TMF_RESP_SLVERR : `TMF_RESP_OKAY;
			end
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			// One read outstanding; address accepted only when idle
			if (do_read) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_word;
				s_axi_rresp   <= rd_ok ? `TMF_RESP_OKAY : `TMF_RESP_SLVERR;
			end
			if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Mode register; standby entry restores reset value
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mode_q    <= `TMF_MODE_RESET;
			standby_q <= 1'b0;
		end else begin
			standby_q <= i_standby;
			if (standby_entry) begin
				mode_q <= `TMF_MODE_RESET;
			end else if (do_write && aw_addr_q == `TMF_OFS_MODE && w_strb_q[0]) begin
				mode_q <= (w_data_q[7:0] & `TMF_MODE_WMASK) | `TMF_MODE_RSVD;
			end
		end
	end

	// Status register: enables, flags and read-armed bits
	// Set wins over a software or DMA clear in the same cycle; standby entry clears even then
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			en_q   <= 3'h0;
			flag_q <= 3'h0;
			seen_q <= 3'h0;
		end else if (standby_entry) begin
			en_q   <= 3'h0;
			flag_q <= 3'h0;
			seen_q <= 3'h0;
		end else begin
			if (do_write && aw_addr_q == `TMF_OFS_STAT_A && w_strb_q[0]) begin
				en_q <= w_data_q[6:4];
			end
			for (i = 0; i < 3; i = i + 1) begin
				// Read of a set flag arms the clear
				if (do_read && s_axi_araddr == `TMF_OFS_STAT_A && flag_q[i]) begin
					seen_q[i] <= 1'b1;
				end else if (sw_clear[i] | i_dma_ack_a[i]) begin
					seen_q[i] <= 1'b0;
				end
				if (set_ev[i]) begin
					flag_q[i] <= 1'b1;
				end else if (sw_clear[i] | (i_dma_ack_a[i] & o_match_a_irq[i])) begin
					flag_q[i] <= 1'b0;
				end
			end
		end
	end

	// Sticky interrupt status and mask; write one clears, event wins
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ist_q        <= 6'h00;
			imask_q      <= 6'h00;
			pin_first_q  <= 1'b0;
			pin_second_q <= 1'b0;
		end else begin
			pin_first_q  <= pin_first;
			pin_second_q <= pin_second;
			if (do_write && aw_addr_q == `TMF_OFS_IRQ_MASK && w_strb_q[0]) begin
				imask_q <= w_data_q[5:0];
			end
			for (i = 0; i < `TMF_IRQ_WIDTH; i = i + 1) begin
				if ((i < 3 && set_ev[i]) || (i == `TMF_IRQ_OVF2 && ovf_ev) || (i == `TMF_IRQ_UNF2 && unf_ev) ||
					(i == `TMF_IRQ_QERR && quad_err)) begin
					ist_q[i] <= 1'b1;
				end else if (do_write && aw_addr_q == `TMF_OFS_IRQ_STAT && w_strb_q[0] && w_data_q[i]) begin
					ist_q[i] <= 1'b0;
				end
			end
		end
	end

	// Registered mode, count, PWM and interrupt outputs
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_pwm_select         <= 3'h0;
			o_capcomp_pin_a      <= 3'h0;
			o_phase_count_select <= 1'b0;
			o_ch2_count_up       <= 1'b0;
			o_ch2_count_down     <= 1'b0;
			o_overflow_flag_set  <= 1'b0;
			o_match_a_irq        <= 3'h0;
			o_irq                <= 1'b0;
		end else begin
			o_pwm_select         <= mode_q[2:0];
			o_phase_count_select <= phase_mode;
			o_ch2_count_up       <= step_up;
			o_ch2_count_down     <= step_down;
			// Underflow ignored when direction bit is one
			o_overflow_flag_set  <= ovf_ev | (unf_ev & ~mode_q[`TMF_BIT_OVERFLOW_FLAG_DIRECTION]);
			o_match_a_irq        <= flag_q & en_q & ~(sw_clear | i_dma_ack_a);
			o_irq                <= |(ist_q & imask_q);
			for (i = 0; i < 3; i = i + 1) begin
				// A match drives high first; B match low
				if (!mode_q[i]) begin
					o_capcomp_pin_a[i] <= 1'b0;
				end else if (i_compare_a_hit[i]) begin
					o_capcomp_pin_a[i] <= 1'b1;
				end else if (i_compare_b_hit[i]) begin
					o_capcomp_pin_a[i] <= 1'b0;
				end
			end
		end
	end
endmodule

// ### verilog/tmf_defs.vh
// Offsets, field positions, reset values and codes for the timer mode and match-A block
`ifndef TMF_DEFS_VH
`define TMF_DEFS_VH
`define TMF_OFS_MODE        8'h00
`define TMF_OFS_STAT_A      8'h04
`define TMF_OFS_IRQ_STAT    8'h08
`define TMF_OFS_IRQ_MASK    8'h0C
`define TMF_MODE_RESET      8'h98
`define TMF_MODE_RSVD       8'h98
`define TMF_MODE_WMASK      8'h67
`define TMF_STAT_RESET      8'h88
`define TMF_STAT_RSVD       8'h88
`define TMF_BIT_PHASE       6
`define TMF_BIT_OVERFLOW_FLAG_DIRECTION        5
`define TMF_EN_LSB          4
`define TMF_IRQ_WIDTH       6
`define TMF_IRQ_OVF2        3
`define TMF_IRQ_UNF2        4
`define TMF_IRQ_QERR        5
`define TMF_RESP_OKAY       2'h0
`define TMF_RESP_SLVERR     2'h2
`define TMF_CNT_MAX         16'hFFFF
`define TMF_CNT_MIN         16'h0000
`endif

// ### verilog/tmf_sync3.v
// Three-stage pin synchroniser with agreement check on the last two stages
module tmf_sync3 (
	// Clock and reset
	input  wire i_clk,
	input  wire i_reset_n,
	// Pin and clean level
	input  wire i_pin,
	output reg  o_level
);
	reg s1_q;
	reg s2_q;
	reg s3_q;

	// Level changes only once stages two and three agree; stage one feeds stage two only
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s1_q    <= 1'b0;
			s2_q    <= 1'b0;
			s3_q    <= 1'b0;
			o_level <= 1'b0;
		end else begin
			s1_q <= i_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				o_level <= s3_q;
			end
		end
	end
endmodule

// ### verilog/tmf_quad.v
// Quadrature edge decoder producing count-up and count-down pulses
module tmf_quad (
	// Clock and reset
	input  wire i_clk,
	input  wire i_reset_n,
	// Synchronised phase levels
	input  wire i_first,
	input  wire i_second,
	// Decoded steps
	output reg  o_up,
	output reg  o_down
);
	reg a_q;
	reg b_q;
	wire a_rise;
	wire a_fall;
	wire b_rise;
	wire b_fall;
	wire dn;
	wire up;

	assign a_rise = i_first & ~a_q;
	assign a_fall = ~i_first & a_q;
	assign b_rise = i_second & ~b_q;
	assign b_fall = ~i_second & b_q;
	// Both edges of both pins count
	assign dn = (a_rise & ~i_second) | (b_rise & i_first) | (a_fall & i_second) | (b_fall & ~i_first);
	assign up = (a_rise & i_second) | (b_rise & ~i_first) | (a_fall & ~i_second) | (b_fall & i_first);

	// Simultaneous edges on both pins are illegal and give no step
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			a_q    <= 1'b0;
			b_q    <= 1'b0;
			o_up   <= 1'b0;
			o_down <= 1'b0;
		end else begin
			a_q    <= i_first;
			b_q    <= i_second;
			o_up   <= up & ~dn;
			o_down <= dn & ~up;
		end
	end
endmodule

// ### tb/tmf_monitor.sv
// Assertions on register reads, PWM pins and channel 2 steps
module tmf_monitor (
	// Clock, reset and read channel
	input wire        i_clk, i_reset_n, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
	input wire [7:0]  s_axi_araddr,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	// Events and mode outputs
	input wire [2:0]  i_compare_a_hit, i_compare_b_hit, o_pwm_select, o_capcomp_pin_a,
	input wire        o_phase_count_select, o_ch2_count_down
);
	logic [7:0] ar_q;
	wire  [2:0] a_win = i_compare_a_hit & ~i_compare_b_hit & o_pwm_select;
	wire  [2:0] b_win = i_compare_b_hit & ~i_compare_a_hit & o_pwm_select;
	wire        rd_ok = s_axi_rvalid && s_axi_rresp == 2'h0;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	// Address of the read in flight, so its answer can be judged
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			ar_q <= 8'h00;
		else if (s_axi_arvalid && s_axi_arready)
			ar_q <= s_axi_araddr;
	end
	mode_rsvd_one_a: assert property (rd_ok && ar_q == 8'h00 |-> (s_axi_rdata[7:0] & 8'h98) == 8'h98)
		else $error("mode reserved bits not one");
	mode_mirror_a:
		assert property (rd_ok && ar_q == 8'h00 |-> {s_axi_rdata[6], s_axi_rdata[2:0]} == {o_phase_count_select, o_pwm_select})
		else $error("mode read differs from mode outputs");
	stat_rsvd_one_a: assert property (rd_ok && ar_q == 8'h04 |-> (s_axi_rdata[7:0] & 8'h88) == 8'h88)
		else $error("status reserved bits not one");
	unmapped_err_a: assert property (s_axi_rvalid && ar_q > 8'h0C |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	pwm_a_high_a: assert property ((o_capcomp_pin_a & $past(a_win)) == $past(a_win))
		else $error("pin not high after A match");
	pwm_b_low_a: assert property ((o_capcomp_pin_a & $past(b_win)) == 3'h0)
		else $error("pin not low after B match");
	pwm_off_low_a: assert property ((o_capcomp_pin_a & ~$past(o_pwm_select)) == 3'h0)
		else $error("pin high outside PWM");
	normal_no_down_a: assert property ((!o_phase_count_select) [*8] |-> !o_ch2_count_down)
		else $error("down step in normal mode");
endmodule

bind tmf_top tmf_monitor tmf_monitor_i (.*);

// ### tb/tmf_dma_model.sv
// DMA controller stand-in answering match-A requests
module tmf_dma_model (
	input  wire        i_clk, i_reset_n, i_slow,
	input  wire  [2:0] i_enable, i_request,
	output logic [2:0] o_ack
);
	logic [1:0] wait_q;
	// One ack pulse per request; slow mode lingers so late clears are seen too
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_ack <= 3'h0;
			wait_q <= 2'h0;
		end else if ((i_request & i_enable) != 3'h0 && o_ack == 3'h0) begin
			wait_q <= wait_q + 2'h1;
			if (!i_slow || wait_q == 2'h3)
				o_ack <= i_request & i_enable;
		end else begin
			o_ack <= 3'h0;
			wait_q <= 2'h0;
		end
	end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the timer mode and match-A block
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        i_clk = 1'b0, i_reset_n = 1'b0, i_standby = 1'b0, i_ch2_normal_tick = 1'b0, tick_en = 1'b0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, i_quad_input_first = 1'b0, i_quad_input_second = 1'b0, dma_slow = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, d;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [2:0]  i_compare_a_hit = 3'h0, i_compare_b_hit = 3'h0, i_capture_a = 3'h0, dma_en = 3'h0;
	logic [15:0] i_ch2_count = 16'h0000;
	logic [1:0]  qseq [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, o_irq;
	wire         o_phase_count_select, o_ch2_count_up, o_ch2_count_down, o_overflow_flag_set;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire  [2:0]  o_pwm_select, o_capcomp_pin_a, o_match_a_irq, i_dma_ack_a;
	int          bad_count = 0, checks = 0, seed = 35147;
	logic [31:0] ups = 32'h0, downs = 32'h0, ovfs = 32'h0;

	tmf_top tmf_top_i (.*);
	tmf_dma_model tmf_dma_model_i (.i_clk, .i_reset_n, .i_slow(dma_slow), .i_enable(dma_en),
		.i_request(o_match_a_irq), .o_ack(i_dma_ack_a));

	// 10 MHz clock
	initial begin
		forever #50 i_clk = ~i_clk;
	end
	// Step counts taken mid-cycle, where outputs are settled
	always @(negedge i_clk) begin
		ups += o_ch2_count_up;
		downs += o_ch2_count_down;
		ovfs += o_overflow_flag_set;
	end
	// Random normal ticks, which phase counting must ignore
	always @(posedge i_clk) begin
		i_ch2_normal_tick <= tick_en && ($random(seed) & 1) != 0;
	end
	// Expected register images
	function automatic [7:0] mode_exp(input [7:0] v);
		mode_exp = (v & 8'h67) | 8'h98;
	endfunction
	function automatic [7:0] stat_exp(input [2:0] en, input [2:0] fl);
		stat_exp = {1'b1, en, 1'b1, fl};
	endfunction
	task automatic chk(input [31:0] seen, input [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Write: address and data together, each dropped once taken
	task automatic wr(input [7:0] a, input [7:0] v, input [1:0] rsp = 2'h0);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge i_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!(s_axi_awready && s_axi_wready) && (s_axi_awvalid || s_axi_wvalid));
		s_axi_bready <= 1'b1;
		do @(posedge i_clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, rsp);
	endtask
	task automatic rd(input [7:0] a, input [7:0] v, input [1:0] rsp = 2'h0);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge i_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge i_clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, {24'h0, v});
		chk(s_axi_rresp, rsp);
	endtask
	task automatic pulse(input [2:0] a, input [2:0] b, input [2:0] c);
		i_compare_a_hit <= a;
		i_compare_b_hit <= b;
		i_capture_a <= c;
		@(posedge i_clk);
		i_compare_a_hit <= 3'h0;
		i_compare_b_hit <= 3'h0;
		i_capture_a <= 3'h0;
		repeat (3) @(posedge i_clk);
	endtask
	// Four quadrature steps; the down walk is the up walk with the pins swapped
	task automatic qrun(input bit up, input [15:0] cnt);
		i_ch2_count <= cnt;
		ups = 0;
		downs = 0;
		ovfs = 0;
		for (int k = 0; k < 4; k++) begin
			{i_quad_input_first, i_quad_input_second} <= up ? qseq[k] : {qseq[k][0], qseq[k][1]};
			repeat (10) @(posedge i_clk);
		end
	endtask
	task automatic done(input string s);
		$display("test %s complete", s);
	endtask
	task automatic final_report;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Cuts a hang short; the tests need about 320 cycles
	initial begin
		repeat (20000) @(posedge i_clk);
		bad_count++;
		final_report();
	end
	initial begin
		repeat (8) @(posedge i_clk);
		i_reset_n <= 1'b1;
		@(posedge i_clk);
		rd(8'h00, 8'h98);
		rd(8'h04, 8'h88);
		rd(8'h10, 8'h00, 2'h2);
		wr(8'h02, 8'hFF, 2'h2);
		done("reset");
		for (int k = 0; k < 8; k++) begin
			d = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($random(seed));
			wr(8'h00, d);
			rd(8'h00, mode_exp(d));
			chk(o_pwm_select, d[2:0]);
			chk(o_phase_count_select, d[6]);
		end
		done("mode");
		wr(8'h04, 8'h77);
		rd(8'h04, stat_exp(3'h7, 3'h0));
		pulse(3'h1, 3'h0, 3'h2);
		chk(o_match_a_irq, 3'h3);
		rd(8'h04, stat_exp(3'h7, 3'h3));
		pulse(3'h4, 3'h0, 3'h0);
		wr(8'h04, 8'h70);
		rd(8'h04, stat_exp(3'h7, 3'h4));
		wr(8'h04, 8'h70);
		rd(8'h04, stat_exp(3'h7, 3'h0));
		wr(8'h04, 8'h00);
		pulse(3'h1, 3'h0, 3'h0);
		chk(o_match_a_irq, 3'h0);
		done("flags");
		chk(o_irq, 1'b0);
		rd(8'h08, 8'h07);
		wr(8'h0C, 8'h04);
		repeat (2) @(posedge i_clk);
		chk(o_irq, 1'b1);
		wr(8'h08, 8'h04);
		repeat (2) @(posedge i_clk);
		chk(o_irq, 1'b0);
		rd(8'h08, 8'h03);
		wr(8'h08, 8'h3F);
		done("interrupt");
		dma_en <= 3'h7;
		wr(8'h04, 8'h70);
		repeat (8) @(posedge i_clk);
		rd(8'h04, stat_exp(3'h7, 3'h0));
		dma_slow <= 1'b1;
		pulse(3'h2, 3'h0, 3'h0);
		repeat (8) @(posedge i_clk);
		rd(8'h04, stat_exp(3'h7, 3'h0));
		dma_en <= 3'h0;
		done("dma");
		wr(8'h00, 8'h07);
		pulse(3'h5, 3'h0, 3'h0);
		chk(o_capcomp_pin_a, 3'h5);
		pulse(3'h0, 3'h1, 3'h0);
		chk(o_capcomp_pin_a, 3'h4);
		done("pwm");
		wr(8'h00, 8'h40);
		tick_en <= 1'b1;
		qrun(1'b1, 16'hFFFF);
		chk(ups, 4);
		chk(ovfs, 4);
		wr(8'h00, 8'h60);
		qrun(1'b0, 16'h0000);
		chk(downs, 4);
		chk(ovfs, 0);
		wr(8'h00, 8'h40);
		qrun(1'b0, 16'h0000);
		chk(ovfs, 4);
		rd(8'h08, 8'h1F);
		{i_quad_input_first, i_quad_input_second} <= 2'b11;
		repeat (10) @(posedge i_clk);
		rd(8'h08, 8'h3F);
		{i_quad_input_first, i_quad_input_second} <= 2'b00;
		repeat (10) @(posedge i_clk);
		tick_en <= 1'b0;
		done("quad");
		wr(8'h00, 8'h67);
		i_standby <= 1'b1;
		repeat (3) @(posedge i_clk);
		i_standby <= 1'b0;
		rd(8'h00, 8'h98);
		rd(8'h04, 8'h88);
		wr(8'h00, 8'h27);
		i_reset_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_reset_n <= 1'b1;
		@(posedge i_clk);
		rd(8'h00, 8'h98);
		done("standby");
		final_report();
	end
endmodule
